/* logic/tmr_presc_cfg.svh */
// Offsets, field positions, reset values and codes of the timer prescaler block
`ifndef TMR_PRESC_CFG_SVH
`define TMR_PRESC_CFG_SVH

// ==========================================================
// Register indexes (byte address = 4 * index)
`define GTC_IDX        10'h023
`define CSEL_IDX       10'h024
`define PSC_IDX        10'h025
`define CNT0_IDX       10'h026
`define CNT1_IDX       10'h027

// ==========================================================
// Field positions
`define SYNC_HOLD_POS  7
`define PSR_POS        0
`define CSEL0_LSB      0
`define CSEL1_LSB      4

// ==========================================================
// Reset values
`define GTC_RESET      8'h00
`define CSEL_RESET     3'h0
`define CNT_RESET      16'h0000
`define PSC_RESET      10'h000

// ==========================================================
// Clock-select codes
`define CS_NONE        3'h0
`define CS_DIRECT      3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7

// ==========================================================
// Prescaler geometry: low bits that must all be ones per tap
`define PSC_W          10
`define DIV8_BITS      3
`define DIV64_BITS     6
`define DIV256_BITS    8
`define DIV1024_BITS   10

`endif

/* logic/tmr_presc_pkg.sv */
// Types shared by the timer prescaler block
package tmr_presc_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_RESP
  } bus_state_e;

  typedef logic [2:0] clk_sel_t;

endpackage

/* logic/count_pin_sync.sv */
// Count pin sampler: half-cycle latch stage, synchroniser and edge detector
`timescale 1ns/1ps
module count_pin_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin
  input  wire logic pin,
  // Detected edges, one-cycle pulses
  output logic      rise,
  output logic      fall
);

  logic lat_ff;
  logic sync_ff;
  logic prev_ff;
  logic rise_ff;
  logic fall_ff;
  logic nxt_rise;
  logic nxt_fall;

  // ==========================================================
  // Latch stage: holds the level seen as the clock falls
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_ff <= 1'b0;
    end else begin
      lat_ff <= pin;
    end
  end

  // ==========================================================
  // Sampling and edge detection
  always_comb begin
    nxt_rise = sync_ff & ~prev_ff;
    nxt_fall = ~sync_ff & prev_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      sync_ff <= lat_ff;
      prev_ff <= sync_ff;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  assign rise = rise_ff;
  assign fall = fall_ff;

endmodule

/* logic/timer_prescaler_clock_select.sv */
// Shared prescaler and per-timer clock selection with APB register access
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "tmr_presc_cfg.svh"

// What this block does
// - One shared prescaler feeds both timers; each has its own select field.
// - Select 1 ticks the timer on every system clock.
// - Selects 2 to 5 pick prescaler taps dividing by 8, 64, 256, 1024.
// - Prescaler runs freely whatever either select field holds.
// - First prescaled tick comes 1 to N+1 cycles after enabling.
// - Count pin sampled every clock, then edge detected.
// - Falling-phase latch stage, then rising-edge registers.
// - Select 7 counts rising pin edges, select 6 falling ones.
// - Pin edge reaches the counter 2.5 to 3.5 cycles later.
// - External pin pulses bypass the prescaler divider.
// - Sync-hold bit set keeps the prescaler reset bit; a kept one halts timers.
// - Clearing sync-hold makes hardware clear the prescaler reset bit.
// - Writing one to prescaler reset resets prescaler; self-clears unless held.
module timer_prescaler_clock_select (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External count pins, one per timer
  input  wire logic [1:0]  external_count_pin,
  // Timer count pulses, one per timer
  output logic      [1:0]  timer_count_clock
);

  // ==========================================================
  // Address decode shared by read and write paths
  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, `GTC_IDX) | hit(addr, `CSEL_IDX) | hit(addr, `PSC_IDX) |
             hit(addr, `CNT0_IDX) | hit(addr, `CNT1_IDX);
  endfunction

  // ==========================================================
  // Tap and source selection for one timer
  function automatic logic pick_tick(
    input tmr_presc_pkg::clk_sel_t sel,
    input logic [`PSC_W-1:0]       psc,
    input logic                    ext_rise,
    input logic                    ext_fall
  );
    case (sel)
      `CS_NONE:     pick_tick = 1'b0;
      `CS_DIRECT:   pick_tick = 1'b1;
      `CS_DIV8:     pick_tick = &psc[`DIV8_BITS-1:0];
      `CS_DIV64:    pick_tick = &psc[`DIV64_BITS-1:0];
      `CS_DIV256:   pick_tick = &psc[`DIV256_BITS-1:0];
      `CS_DIV1024:  pick_tick = &psc[`DIV1024_BITS-1:0];
      `CS_EXT_FALL: pick_tick = ext_fall;
      `CS_EXT_RISE: pick_tick = ext_rise;
      default:      pick_tick = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Declarations
  tmr_presc_pkg::bus_state_e bus_state_ff;
  tmr_presc_pkg::bus_state_e nxt_bus_state;
  logic        [31:0]        prdata_ff;
  logic        [31:0]        nxt_prdata;
  logic                      pready_ff;
  logic                      nxt_pready;
  logic                      pslverr_ff;
  logic                      nxt_pslverr;
  logic                      commit_wr;

  logic                      sync_hold_ff;
  logic                      nxt_sync_hold;
  logic                      psr_ff;
  logic                      nxt_psr;

  tmr_presc_pkg::clk_sel_t   csel_ff     [2];
  tmr_presc_pkg::clk_sel_t   nxt_csel    [2];

  logic        [`PSC_W-1:0]  psc_ff;
  logic        [`PSC_W-1:0]  nxt_psc;

  logic        [1:0]         ext_rise;
  logic        [1:0]         ext_fall;
  logic        [1:0]         tick_ff;
  logic        [1:0]         nxt_tick;
  logic        [15:0]        cnt_ff      [2];
  logic        [15:0]        nxt_cnt     [2];
  logic        [1:0]         cnt_clr;

  // ==========================================================
  // APB handshake: one wait state, answer in the second access cycle
  always_comb begin
    nxt_bus_state = bus_state_ff;
    nxt_pready    = 1'b0;
    nxt_pslverr   = 1'b0;
    nxt_prdata    = 32'h0000_0000;
    case (bus_state_ff)
      tmr_presc_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          nxt_bus_state = tmr_presc_pkg::BUS_RESP;
          nxt_pready    = 1'b1;
          nxt_pslverr   = ~mapped(paddr);
          if (!pwrite) begin
            if (hit(paddr, `GTC_IDX)) begin
              nxt_prdata[`SYNC_HOLD_POS] = sync_hold_ff;
              nxt_prdata[`PSR_POS]       = psr_ff;
            end
            if (hit(paddr, `CSEL_IDX)) begin
              nxt_prdata[`CSEL0_LSB+2:`CSEL0_LSB] = csel_ff[0];
              nxt_prdata[`CSEL1_LSB+2:`CSEL1_LSB] = csel_ff[1];
            end
            if (hit(paddr, `PSC_IDX)) begin
              nxt_prdata[`PSC_W-1:0] = psc_ff;
            end
            if (hit(paddr, `CNT0_IDX)) begin
              nxt_prdata[15:0] = cnt_ff[0];
            end
            if (hit(paddr, `CNT1_IDX)) begin
              nxt_prdata[15:0] = cnt_ff[1];
            end
          end
        end
      end
      tmr_presc_pkg::BUS_RESP: begin
        nxt_bus_state = tmr_presc_pkg::BUS_IDLE;
      end
      default: begin
        nxt_bus_state = tmr_presc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_ff <= tmr_presc_pkg::BUS_IDLE;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      prdata_ff    <= 32'h0000_0000;
    end else begin
      bus_state_ff <= nxt_bus_state;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      prdata_ff    <= nxt_prdata;
    end
  end

  // Writes land only on the edge that completes the access
  assign commit_wr = psel && penable && pwrite && pready_ff;

  // ==========================================================
  // General timer control: sync-hold and prescaler reset
  always_comb begin
    nxt_sync_hold = sync_hold_ff;
    // Without hold the reset bit lives one cycle only
    nxt_psr       = psr_ff & sync_hold_ff;
    if (commit_wr && hit(paddr, `GTC_IDX)) begin
      nxt_sync_hold = pwdata[`SYNC_HOLD_POS];
      if (pwdata[`SYNC_HOLD_POS]) begin
        // Hold keeps whatever was written, including a zero
        nxt_psr = pwdata[`PSR_POS];
      end else begin
        // Leaving hold releases the prescaler unless a new pulse is asked for
        nxt_psr = pwdata[`PSR_POS];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_hold_ff <= 1'(`GTC_RESET >> `SYNC_HOLD_POS);
      psr_ff       <= 1'(`GTC_RESET >> `PSR_POS);
    end else begin
      sync_hold_ff <= nxt_sync_hold;
      psr_ff       <= nxt_psr;
    end
  end

  // ==========================================================
  // Clock-select fields, one per timer
  always_comb begin
    nxt_csel[0] = csel_ff[0];
    nxt_csel[1] = csel_ff[1];
    if (commit_wr && hit(paddr, `CSEL_IDX)) begin
      nxt_csel[0] = pwdata[`CSEL0_LSB+2:`CSEL0_LSB];
      nxt_csel[1] = pwdata[`CSEL1_LSB+2:`CSEL1_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csel_ff[0] <= `CSEL_RESET;
      csel_ff[1] <= `CSEL_RESET;
    end else begin
      csel_ff[0] <= nxt_csel[0];
      csel_ff[1] <= nxt_csel[1];
    end
  end

  // ==========================================================
  // Shared free-running prescaler
  always_comb begin
    if (psr_ff) begin
      nxt_psc = `PSC_RESET;
    end else begin
      // No select field takes part here, so only the reset bit, never a select change, shifts tap phase
      nxt_psc = psc_ff + `PSC_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_ff <= `PSC_RESET;
    end else begin
      psc_ff <= nxt_psc;
    end
  end

  // ==========================================================
  // Per-timer pin sampling, source selection and tick counting
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      count_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (external_count_pin[gi]),
        .rise    (ext_rise[gi]),
        .fall    (ext_fall[gi])
      );

      // Edge detector runs all the time, so switching select in never
      // replays a stale edge, given a steady pin
      always_comb begin
        if (psr_ff) begin
          // Held reset keeps every source of this timer quiet
          nxt_tick[gi] = 1'b0;
        end else begin
          // Pin edges go straight to the tick, never into the divider
          nxt_tick[gi] = pick_tick(csel_ff[gi], psc_ff,
                                   ext_rise[gi], ext_fall[gi]);
        end
      end

      assign cnt_clr[gi] = commit_wr &&
                           hit(paddr, (gi == 0) ? `CNT0_IDX : `CNT1_IDX);

      always_comb begin
        nxt_cnt[gi] = cnt_ff[gi];
        if (tick_ff[gi]) begin
          nxt_cnt[gi] = cnt_ff[gi] + 16'h0001;
        end
        // A tick in the clearing cycle is kept, counting from zero
        if (cnt_clr[gi]) begin
          nxt_cnt[gi] = {15'h0000, tick_ff[gi]};
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tick_ff[gi] <= 1'b0;
          cnt_ff[gi]  <= `CNT_RESET;
        end else begin
          tick_ff[gi] <= nxt_tick[gi];
          cnt_ff[gi]  <= nxt_cnt[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Outputs straight from flops
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign timer_count_clock = tick_ff;

endmodule

/* sim/ext_count_source.sv */
// Model of the signal source that drives one count pin
`timescale 1ns/1ps
module ext_count_source (
  // Clock
  input  wire logic       pclk,
  // Control from the bench
  input  wire logic       run,
  input  wire logic [7:0] half,
  // Count pin
  output logic            pin
);
  logic [7:0] n_ff;
  initial begin
    pin = 1'b0;
    n_ff = 8'h00;
  end
  // Stops only once low, so selects change while the pin is steady
  always @(posedge pclk) begin
    if (n_ff + 8'h01 >= half) begin
      n_ff <= 8'h00;
      if (run || pin) pin <= !pin;
    end else begin
      n_ff <= n_ff + 8'h01;
    end
  end
endmodule

/* sim/timer_prescaler_clock_select_properties.sv */
// Checker for the timer prescaler block, bound to its top module
`timescale 1ns/1ps
`include "tmr_presc_cfg.svh"
module timer_prescaler_clock_select_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and pulses
  input wire logic [1:0]  external_count_pin,
  input wire logic [1:0]  timer_count_clock
);
  // ==========================================================
  // Shadows of committed select and control writes
  logic       wr_done;
  logic       gtc_wr;
  logic       sel_wr;
  logic       quiet;
  logic [2:0] sel0_ff;
  logic [2:0] sel1_ff;
  logic       hold_ff;
  logic       held_ff;
  assign wr_done = psel && penable && pready && pwrite;
  assign gtc_wr  = wr_done && paddr == {`GTC_IDX, 2'b00};
  assign sel_wr  = wr_done && paddr == {`CSEL_IDX, 2'b00};
  assign quiet   = !hold_ff && !gtc_wr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel0_ff <= 3'h0;
      sel1_ff <= 3'h0;
      hold_ff <= 1'b0;
      held_ff <= 1'b0;
    end else begin
      if (sel_wr) sel0_ff <= pwdata[2:0];
      if (sel_wr) sel1_ff <= pwdata[6:4];
      if (gtc_wr) hold_ff <= pwdata[7];
      if (gtc_wr) held_ff <= pwdata[7] && pwdata[0];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access phase");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside response");
  a_direct_every: assert property ((sel0_ff == `CS_DIRECT && quiet)[*4]
    |-> timer_count_clock[0]) else $error("direct select missed a cycle");
  a_none_silent: assert property ((sel0_ff == `CS_NONE)[*3]
    |-> !timer_count_clock[0]) else $error("pulse with no source selected");
  a_hold_halts: assert property (held_ff[*2] |-> timer_count_clock == 2'b00)
    else $error("pulse while prescaler reset held");
  a_div8_period: assert property (timer_count_clock[0] && sel0_ff == `CS_DIV8 && quiet
    && !$past(sel_wr)
    |=> ((!timer_count_clock[0])[*7] ##1 timer_count_clock[0]) or (##[0:7] (sel_wr || gtc_wr)))
    else $error("divide by 8 tap period wrong");
  a_ext_rise: assert property ($rose(external_count_pin[1]) && sel1_ff == `CS_EXT_RISE
    && quiet |-> ##[3:4] timer_count_clock[1]) else $error("rising pin edge not counted");
  a_ext_fall: assert property ($fell(external_count_pin[0]) && sel0_ff == `CS_EXT_FALL
    && quiet |-> ##[3:4] timer_count_clock[0]) else $error("falling pin edge not counted");
endmodule
bind timer_prescaler_clock_select timer_prescaler_clock_select_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_count_pin(external_count_pin), .timer_count_clock(timer_count_clock));

/* sim/tb_timer_prescaler_clock_select.sv */
// Self-checking bench for the timer prescaler block
`timescale 1ns/1ps
`include "tmr_presc_cfg.svh"
module tb_timer_prescaler_clock_select;
  localparam logic [11:0] adr_gtc = {`GTC_IDX, 2'b00};
  localparam logic [11:0] adr_sel = {`CSEL_IDX, 2'b00};
  localparam logic [11:0] adr_psc = {`PSC_IDX, 2'b00};
  localparam logic [11:0] adr_c0  = {`CNT0_IDX, 2'b00};
  localparam logic [11:0] adr_c1  = {`CNT1_IDX, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  pin, pin_q, tcc, run;
  int          n_fail = 0, checked = 0, seen0 = 0, seen1 = 0, edg0 = 0, edg1 = 0;
  int          b0, b1, s0, s1, t;
  int          divs[4] = '{8, 64, 256, 1024};
  ext_count_source u_src0 (.pclk(pclk), .run(run[0]), .half(8'h02), .pin(pin[0]));
  ext_count_source u_src1 (.pclk(pclk), .run(run[1]), .half(8'h03), .pin(pin[1]));
  timer_prescaler_clock_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(pin), .timer_count_clock(tcc));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Expected edge counts come from the pins, not from the design
  always @(posedge pclk) begin
    seen0 <= seen0 + int'(tcc[0]);
    seen1 <= seen1 + int'(tcc[1]);
    edg0 <= edg0 + int'(pin_q[0] && !pin[0]);
    edg1 <= edg1 + int'(!pin_q[1] && pin[1]);
    pin_q <= pin;
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic rdc(string what, logic [11:0] a, logic [31:0] exp, logic ee);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
    cmp({what, " err"}, {31'h0, ee}, {31'h0, er});
  endtask
  task automatic wait_tick();
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (tcc[0] !== 1'b1 && t < 2000);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rdc("ctrl reset", adr_gtc, 32'h0, 1'b0);
    rdc("select reset", adr_sel, 32'h0, 1'b0);
    rdc("unmapped", 12'h0a0, 32'h0, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_direct();
    apb(1'b1, adr_sel, 32'h01);
    repeat (3) @(posedge pclk);
    b0 = seen0;
    b1 = seen1;
    repeat (40) @(posedge pclk);
    cmp("direct pulses", 32'd40, 32'(seen0 - b0));
    cmp("other timer idle", 32'd0, 32'(seen1 - b1));
    apb(1'b1, adr_sel, 32'h00);
    apb(1'b0, adr_psc, 32'h0);
    b0 = seen0;
    s0 = int'(rd);
    repeat (20) @(posedge pclk);
    apb(1'b0, adr_psc, 32'h0);
    cmp("prescaler runs", 32'((s0 + 24) % 1024), rd);
    cmp("no source pulses", 32'd0, 32'(seen0 - b0));
    $display("test direct done");
  endtask
  task automatic t_taps();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, adr_sel, 32'((5 - i) << 4 | (2 + i)));
      wait_tick();
      cmp("first tick", 32'h1, {31'h0, t >= 1 && t <= divs[i] + 1});
      wait_tick();
      cmp("tap period", 32'(divs[i]), 32'(t));
    end
    $display("test taps done");
  endtask
  task automatic t_psr();
    apb(1'b1, adr_sel, 32'h12);
    apb(1'b1, adr_gtc, 32'h01);
    rdc("reset bit self clears", adr_gtc, 32'h0, 1'b0);
    apb(1'b1, adr_gtc, 32'h81);
    apb(1'b1, adr_psc, 32'h3ff);
    rdc("reset bit kept", adr_gtc, 32'h81, 1'b0);
    rdc("prescaler held", adr_psc, 32'h0, 1'b0);
    b0 = seen0;
    b1 = seen1;
    repeat (50) @(posedge pclk);
    cmp("halted pulses", 32'd0, 32'(seen0 - b0 + seen1 - b1));
    apb(1'b1, adr_gtc, 32'h00);
    wait_tick();
    cmp("restart tick", 32'h1, {31'h0, t <= 9});
    rdc("reset bit cleared", adr_gtc, 32'h0, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_ext();
    apb(1'b1, adr_sel, 32'h76);
    apb(1'b1, adr_c0, 32'h0);
    apb(1'b1, adr_c1, 32'h0);
    {b0, b1, s0, s1} = {edg0, edg1, seen0, seen1};
    run <= 2'b11;
    repeat (60) @(posedge pclk);
    run <= 2'b00;
    repeat (20) @(posedge pclk);
    cmp("falling edges", 32'(edg0 - b0), 32'(seen0 - s0));
    cmp("rising edges", 32'(edg1 - b1), 32'(seen1 - s1));
    rdc("count0 reg", adr_c0, 32'(edg0 - b0), 1'b0);
    rdc("count1 reg", adr_c1, 32'(edg1 - b1), 1'b0);
    $display("test ext done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run, pin_q} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_direct();
    t_taps();
    t_psr();
    t_ext();
    complete_run();
  end
endmodule
